// file: fcs_pkg.sv
// How it works
// [R1] Identification entry only when no operation runs
// [R2] Identification entry: two unlocks, bank command
// [R3] Identification mode left only by reset
// [R4] Secure region: three-cycle entry, four-cycle exit
// [R5] Device refuses secure region while busy
// [R6] No bypass or acceleration inside secure region
// [R7] Program: two unlocks, set-up, address/data
// [R8] Device hides secure/identify/query while busy
// [R9] Bank back to read after programming
// [R10] Commands ignored during program; hardware reset aborts
// [R11] Programming only clears bits
// [R12] Bypass entry 20h; bypass program A0h then data
// [R13] Bypass accepts only program and two-cycle reset
// [R14] High-voltage protect pin forces bypass mode
// [R15] Chip erase: six write cycles
// [R16] Device preprograms to zero before erase
// [R17] Commands ignored during chip erase
// [R18] Sector erase: six cycles, sector address last
// [R19] Added sectors within 80 us window
// [R20] Other command in window returns read mode; the code refuses identify, secure, bypass and erase entry there, window kept
// [R21] Running sector erase accepts only suspend; the code refuses suspend then, as sect_run_reg clears one cycle after launch
// [R22] Reset command returns read, keeps embedded operation
// [R23] Suspend B0h only for sector erase
// [R24] Word unlocks AA at 555, 55 at 2AA
package fcs_pkg;
    localparam int FCS_AW = 23;
    localparam int FCS_DW = 16;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;
    localparam int CTRL_BYTE = 0;
    localparam int CTRL_ACCEL = 1;
    localparam int CTRL_HWRST = 2;
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_AUTOSEL = 2;
    localparam int ST_SECURE = 3;
    localparam int ST_BYPASS = 4;
    localparam int ST_WINDOW = 5;
    localparam int ST_READY = 6;
    localparam int ST_SUSPEND = 7;
    localparam logic [FCS_DW-1:0] D_UNLOCK1 = 16'h00AA;
    localparam logic [FCS_DW-1:0] D_UNLOCK2 = 16'h0055;
    localparam logic [FCS_DW-1:0] D_AUTOSEL = 16'h0090;
    localparam logic [FCS_DW-1:0] D_SECURE = 16'h0088;
    localparam logic [FCS_DW-1:0] D_PROG = 16'h00A0;
    localparam logic [FCS_DW-1:0] D_BYPASS = 16'h0020;
    localparam logic [FCS_DW-1:0] D_ERASE_SETUP = 16'h0080;
    localparam logic [FCS_DW-1:0] D_CHIP = 16'h0010;
    localparam logic [FCS_DW-1:0] D_SECTOR = 16'h0030;
    localparam logic [FCS_DW-1:0] D_SUSPEND = 16'h00B0;
    localparam logic [FCS_DW-1:0] D_RESUME = 16'h0030;
    localparam logic [FCS_DW-1:0] D_RESET = 16'h00F0;
    localparam logic [FCS_DW-1:0] D_EXIT = 16'h0000;
    localparam logic [11:0] A_U1_WORD = 12'h555;
    localparam logic [11:0] A_U2_WORD = 12'h2AA;
    localparam logic [11:0] A_U1_BYTE = 12'hAAA;
    localparam logic [11:0] A_U2_BYTE = 12'h555;
    localparam int CLK_HZ = 20000000;
    localparam int WINDOW_US = 80;
    localparam int WINDOW_CYC = WINDOW_US * (CLK_HZ / 1000000);
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        CMD_READ = 4'h0, CMD_RESET = 4'h1, CMD_AUTOSEL = 4'h2, CMD_SEC_ENTER = 4'h3,
        CMD_SEC_EXIT = 4'h4, CMD_PROG = 4'h5, CMD_BYP_ENTER = 4'h6, CMD_BYP_PROG = 4'h7,
        CMD_BYP_RESET = 4'h8, CMD_CHIP_ERASE = 4'h9, CMD_SECT_ERASE = 4'hA, CMD_SECT_ADD = 4'hB,
        CMD_SUSPEND = 4'hC, CMD_RESUME = 4'hD
    } fcs_cmd_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_W_SETUP = 3'h1, ST_W_STROBE = 3'h2, ST_W_HOLD = 3'h3, ST_R_WAIT = 3'h4
    } fcs_state_type;
    typedef struct packed {
        logic [FCS_AW-1:0] addr;
        logic [FCS_DW-1:0] data;
    } fcs_cycle_type;
    typedef struct packed {
        logic [FCS_AW-1:0] addr;
        logic [FCS_DW-1:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic byte_n;
        logic reset_n;
        logic protect_accel_pin;
    } fcs_pins_type;
endpackage

// file: fcs_host.sv
`timescale 1ns/10ps
module fcs_host import fcs_pkg::*; #(
    parameter int SETUP_CYC = 1,
    parameter int STROBE_CYC = 2,
    parameter int HOLD_CYC = 1,
    parameter int READ_CYC = 6
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output fcs_pins_type flash_pins,
    input wire logic [FCS_DW-1:0] flash_dq_in,
    input wire logic ready_busy_output
);
    function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] cycle_count(input fcs_cmd_type c);
        case (c)
            CMD_AUTOSEL, CMD_SEC_ENTER, CMD_BYP_ENTER: cycle_count = 3'd3;
            CMD_SEC_EXIT, CMD_PROG: cycle_count = 3'd4;
            CMD_BYP_PROG, CMD_BYP_RESET: cycle_count = 3'd2;
            CMD_CHIP_ERASE, CMD_SECT_ERASE: cycle_count = 3'd6;
            default: cycle_count = 3'd1;
        endcase
    endfunction

    function automatic fcs_cycle_type cycle_word(input fcs_cmd_type c, input logic [2:0] idx, input logic byte_m,
                                                 input logic [FCS_AW-1:0] a, input logic [FCS_DW-1:0] d);
        fcs_cycle_type r;
        logic [FCS_AW-1:0] u1;
        logic [FCS_AW-1:0] u2;
        logic [FCS_AW-1:0] ba;
        u1 = FCS_AW'(byte_m ? A_U1_BYTE : A_U1_WORD); // see [R24]
        u2 = FCS_AW'(byte_m ? A_U2_BYTE : A_U2_WORD);
        ba = {a[FCS_AW-1:12], u1[11:0]};
        r.addr = a;
        r.data = d; // see [R11]
        if (c == CMD_SECT_ADD || c == CMD_SUSPEND || c == CMD_RESUME || c == CMD_RESET) begin
            r.data = (c == CMD_SECT_ADD) ? D_SECTOR : (c == CMD_SUSPEND) ? D_SUSPEND :
                     (c == CMD_RESUME) ? D_RESUME : D_RESET; // see [R19] see [R22] see [R23]
        end else if (c == CMD_BYP_PROG || c == CMD_BYP_RESET) begin
            if (idx == 3'd0) begin
                r.data = (c == CMD_BYP_PROG) ? D_PROG : D_AUTOSEL; // see [R12] see [R13]
            end else if (c == CMD_BYP_RESET) begin
                r.data = D_EXIT;
            end
        end else if (idx == 3'd0 || (idx == 3'd3 && cycle_count(c) == 3'd6)) begin
            r.addr = u1;
            r.data = D_UNLOCK1; // see [R24]
        end else if (idx == 3'd1 || idx == 3'd4) begin
            r.addr = u2;
            r.data = D_UNLOCK2;
        end else if (idx == 3'd2) begin
            r.addr = (c == CMD_AUTOSEL) ? ba : u1; // see [R2]
            case (c)
                CMD_AUTOSEL, CMD_SEC_EXIT: r.data = D_AUTOSEL;
                CMD_SEC_ENTER: r.data = D_SECURE; // see [R4]
                CMD_PROG: r.data = D_PROG; // see [R7]
                CMD_BYP_ENTER: r.data = D_BYPASS; // see [R12]
                default: r.data = D_ERASE_SETUP; // see [R15] see [R18]
            endcase
        end else if (c == CMD_SEC_EXIT) begin
            r.data = D_EXIT; // see [R4]
        end else if (c == CMD_CHIP_ERASE) begin
            r.addr = u1;
            r.data = D_CHIP; // see [R15] see [R16]
        end else if (c == CMD_SECT_ERASE) begin
            r.data = D_SECTOR; // see [R18]
        end
        return r;
    endfunction

    logic aw_held_reg, w_held_reg;
    logic [7:0] awaddr_reg, araddr_unused;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [31:0] ctrl_reg, addr_reg, data_reg, rdata_reg;
    logic autosel_reg, secure_reg, bypass_reg, suspend_reg, refused_reg, sect_run_reg;
    logic [11:0] window_reg;
    logic [2:0] rb_sync_reg;
    logic rb_stable_reg;
    logic [FCS_DW-1:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
    fcs_state_type state_reg;
    fcs_cmd_type cmd_reg, new_cmd;
    logic [2:0] idx_reg;
    logic [7:0] cnt_reg;
    fcs_cycle_type cyc;
    logic wr_en, launch, allowed, accel_eff, bypass_eff, window_on, oprun, last_cycle, seq_done;

    assign wr_en = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign araddr_unused = s_axi_araddr;
    assign new_cmd = fcs_cmd_type'(wdata_reg[3:0]);
    assign launch = wr_en && awaddr_reg == REG_CMD && wstrb_reg[0];
    assign accel_eff = ctrl_reg[CTRL_ACCEL] && !secure_reg; // see [R6]
    assign bypass_eff = bypass_reg || accel_eff; // see [R14]
    assign window_on = window_reg != 12'd0;
    assign oprun = !rb_stable_reg;
    assign last_cycle = idx_reg == cycle_count(cmd_reg) - 3'd1;
    assign seq_done = state_reg == ST_W_HOLD && cnt_reg == 8'(HOLD_CYC - 1) && last_cycle;
    assign cyc = cycle_word(cmd_reg, idx_reg, ctrl_reg[CTRL_BYTE], addr_reg[FCS_AW-1:0], data_reg[FCS_DW-1:0]);

    always_comb begin
        allowed = state_reg == ST_IDLE && !ctrl_reg[CTRL_HWRST];
        if (oprun) begin // see [R5] see [R8]
            allowed = allowed && (new_cmd == CMD_READ ||
                      (new_cmd == CMD_SUSPEND && sect_run_reg && !suspend_reg)); // see [R10] see [R17] see [R21] see [R23]
        end else if (autosel_reg) begin
            allowed = allowed && (new_cmd == CMD_READ || new_cmd == CMD_RESET); // see [R3]
        end else if (bypass_eff) begin
            allowed = allowed && (new_cmd == CMD_READ || new_cmd == CMD_BYP_PROG ||
                      (new_cmd == CMD_BYP_RESET && !accel_eff)); // see [R13]
        end else begin
            case (new_cmd)
                CMD_AUTOSEL: allowed = allowed && !window_on; // see [R1]
                CMD_SEC_ENTER: allowed = allowed && !window_on && !suspend_reg;
                CMD_BYP_ENTER: allowed = allowed && !secure_reg && !window_on; // see [R6]
                CMD_BYP_PROG, CMD_BYP_RESET: allowed = 1'b0;
                CMD_SECT_ADD: allowed = allowed && window_on; // see [R19]
                CMD_SUSPEND: allowed = allowed && window_on && !suspend_reg; // see [R23]
                CMD_RESUME: allowed = allowed && suspend_reg;
                CMD_CHIP_ERASE, CMD_SECT_ERASE: allowed = allowed && !suspend_reg && !window_on;
                CMD_READ, CMD_RESET, CMD_SEC_EXIT, CMD_PROG: allowed = allowed;
                default: allowed = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_reg <= REG_STATUS && awaddr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= ctrl_reg;
                REG_ADDR: s_axi_rdata <= addr_reg;
                REG_DATA: s_axi_rdata <= data_reg;
                REG_CMD: s_axi_rdata <= {28'h0000000, cmd_reg};
                REG_STATUS: s_axi_rdata <= {24'h000000, suspend_reg, rb_stable_reg, window_on, bypass_eff,
                                            secure_reg, autosel_reg, refused_reg, state_reg != ST_IDLE};
                REG_RDATA: s_axi_rdata <= rdata_reg;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_reg <= 32'h00000000;
            addr_reg <= 32'h00000000;
            data_reg <= 32'h00000000;
        end else if (wr_en) begin
            if (awaddr_reg == REG_CTRL) begin
                ctrl_reg <= strb_merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h00000007;
            end
            if (awaddr_reg == REG_ADDR) begin
                addr_reg <= strb_merge(addr_reg, wdata_reg, wstrb_reg);
            end
            if (awaddr_reg == REG_DATA) begin
                data_reg <= strb_merge(data_reg, wdata_reg, wstrb_reg);
            end
        end
    end

    // Ready/busy and data pins pass three stages; a level counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rb_sync_reg <= 3'h7;
            rb_stable_reg <= 1'b1;
            dq_s1_reg <= 16'h0000;
            dq_s2_reg <= 16'h0000;
            dq_s3_reg <= 16'h0000;
        end else begin
            rb_sync_reg <= {rb_sync_reg[1:0], ready_busy_output};
            if (rb_sync_reg[1] == rb_sync_reg[2]) begin
                rb_stable_reg <= rb_sync_reg[2]; // see [R9]
            end
            dq_s1_reg <= flash_dq_in;
            dq_s2_reg <= dq_s1_reg;
            dq_s3_reg <= dq_s2_reg;
        end
    end

    // Mode tracking and refusal flag
    always_ff @(posedge core_clk) begin
        if (srst || ctrl_reg[CTRL_HWRST]) begin
            autosel_reg <= 1'b0; // see [R10] see [R17]
            secure_reg <= 1'b0;
            bypass_reg <= 1'b0;
            suspend_reg <= 1'b0;
            sect_run_reg <= 1'b0;
            refused_reg <= srst ? 1'b0 : refused_reg;
        end else begin
            if (wr_en && awaddr_reg == REG_STATUS && wstrb_reg[0] && wdata_reg[ST_REFUSED]) begin
                refused_reg <= 1'b0;
            end
            if (launch && !allowed) begin
                refused_reg <= 1'b1;
            end
            if (rb_stable_reg && !window_on && !suspend_reg) begin
                sect_run_reg <= 1'b0;
            end
            if (launch && allowed) begin
                case (new_cmd)
                    CMD_AUTOSEL: autosel_reg <= 1'b1; // see [R2]
                    CMD_RESET: autosel_reg <= 1'b0; // see [R3] see [R22]
                    CMD_SEC_ENTER: secure_reg <= 1'b1; // see [R4]
                    CMD_SEC_EXIT: secure_reg <= 1'b0;
                    CMD_BYP_ENTER: bypass_reg <= 1'b1; // see [R12]
                    CMD_BYP_RESET: bypass_reg <= 1'b0; // see [R13]
                    CMD_SECT_ERASE: sect_run_reg <= 1'b1;
                    CMD_SUSPEND: suspend_reg <= 1'b1; // see [R23]
                    CMD_RESUME: suspend_reg <= 1'b0;
                    default: sect_run_reg <= sect_run_reg;
                endcase
            end
        end
    end

    // Accumulation window restarts when select rises at the end of the last write of each sector command
    always_ff @(posedge core_clk) begin
        if (srst || ctrl_reg[CTRL_HWRST]) begin
            window_reg <= 12'd0;
        end else if (seq_done && (cmd_reg == CMD_SECT_ERASE || cmd_reg == CMD_SECT_ADD)) begin
            window_reg <= 12'(WINDOW_CYC); // see [R19]
        end else if (launch && allowed && new_cmd != CMD_READ && new_cmd != CMD_SECT_ADD) begin
            window_reg <= 12'd0; // see [R20]
        end else if (window_on) begin
            window_reg <= window_reg - 12'd1;
        end
    end

    // Bus cycle engine drives one write or read cycle at a time
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            cmd_reg <= CMD_READ;
            idx_reg <= 3'd0;
            cnt_reg <= 8'd0;
            rdata_reg <= 32'h00000000;
            flash_pins <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                            byte_n: 1'b1, reset_n: 1'b0, protect_accel_pin: 1'b0};
        end else begin
            flash_pins.byte_n <= !ctrl_reg[CTRL_BYTE];
            flash_pins.reset_n <= !ctrl_reg[CTRL_HWRST]; // see [R10] see [R17]
            flash_pins.protect_accel_pin <= accel_eff; // see [R6] see [R14]
            cnt_reg <= cnt_reg + 8'd1;
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 8'd0;
                    idx_reg <= 3'd0;
                    if (launch && allowed) begin
                        cmd_reg <= new_cmd;
                        flash_pins.ce_n <= 1'b0;
                        flash_pins.addr <= addr_reg[FCS_AW-1:0];
                        flash_pins.oe_n <= new_cmd != CMD_READ;
                        state_reg <= (new_cmd == CMD_READ) ? ST_R_WAIT : ST_W_SETUP;
                    end
                end
                ST_W_SETUP: begin
                    flash_pins.ce_n <= 1'b0;
                    flash_pins.addr <= cyc.addr;
                    flash_pins.dq_out <= cyc.data;
                    flash_pins.dq_oe <= 1'b1;
                    if (cnt_reg >= 8'(SETUP_CYC)) begin // Select and address settle before the strobe falls
                        cnt_reg <= 8'd0;
                        flash_pins.we_n <= 1'b0;
                        state_reg <= ST_W_STROBE;
                    end
                end
                ST_W_STROBE: begin
                    if (cnt_reg >= 8'(STROBE_CYC - 1)) begin
                        cnt_reg <= 8'd0;
                        flash_pins.we_n <= 1'b1;
                        state_reg <= ST_W_HOLD;
                    end
                end
                ST_W_HOLD: begin
                    if (cnt_reg >= 8'(HOLD_CYC - 1)) begin
                        cnt_reg <= 8'd0;
                        flash_pins.ce_n <= 1'b1;
                        flash_pins.dq_oe <= 1'b0;
                        idx_reg <= idx_reg + 3'd1;
                        state_reg <= last_cycle ? ST_IDLE : ST_W_SETUP; // see [R7] see [R15] see [R18]
                    end
                end
                ST_R_WAIT: begin
                    if (cnt_reg >= 8'(READ_CYC - 1) && dq_s2_reg == dq_s3_reg) begin
                        rdata_reg <= {16'h0000, dq_s3_reg};
                        flash_pins.ce_n <= 1'b1;
                        flash_pins.oe_n <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

// file: fcs_host_asserts.sv
`timescale 1ns/10ps
module fcs_host_asserts import fcs_pkg::*; (
    input wire logic core_clk,
    input wire logic srst,
    input wire fcs_pins_type flash_pins,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    wire logic we_n = flash_pins.we_n;
    wire logic ce_n = flash_pins.ce_n;
    wire logic oe_n = flash_pins.oe_n;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    AST_WE_IN_CE: assert property (!we_n |-> !ce_n) else $error("strobe without select");
    AST_CE_FIRST: assert property ($fell(we_n) |-> $past(!ce_n)) else $error("no select setup");
    AST_WE_DRIVES: assert property (!we_n |-> oe_n && flash_pins.dq_oe) else $error("strobe while reading");
    AST_RD_FREE: assert property (!oe_n |-> !flash_pins.dq_oe) else $error("bus fight on read");
    AST_STROBE: assert property ($fell(we_n) |=> !we_n ##[1:3] we_n) else $error("bad strobe width");
    AST_ADDR_HOLD: assert property (!we_n |=> we_n || $stable(flash_pins.addr)) else $error("addr moved");
    AST_DATA_HOLD: assert property (!we_n |=> we_n || $stable(flash_pins.dq_out)) else $error("data moved");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not held");
    AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read not held");
endmodule
bind fcs_host fcs_host_asserts i_fcs_host_asserts (.core_clk, .srst, .flash_pins, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid);

// file: fcs_flash_model.sv
`timescale 1ns/10ps
module fcs_flash_model import fcs_pkg::*; #(
    parameter logic [15:0] ID_CODE = 16'h5A5A, // Arbitrary value
    parameter int BUSY_NS = 2000
) (
    input wire fcs_pins_type pins,
    output logic [FCS_DW-1:0] dq,
    output logic rdy
);
    logic [15:0] mem [16] = '{default: 16'hFFFF};
    logic [15:0] rd = 16'h0;
    logic [15:0] pd, d;
    logic [3:0] pa;
    logic idm = 0, sec = 0, byp = 0, ers = 0, win = 0;
    int step = 0, op = 0, gen = 0;
    wire logic acc = pins.protect_accel_pin && !sec;
    initial rdy = 1;
    assign dq = pins.oe_n ? ~rd : rd;
    always @(negedge pins.oe_n) rd = idm ? ID_CODE : mem[pins.addr[3:0]];
    task automatic run(input int g);
        if (win) #(80000);
        if (g != gen || op == 0) return;
        rdy = 0;
        fork
            #(BUSY_NS);
            @(negedge pins.reset_n);
        join_any
        disable fork;
        if (pins.reset_n && op == 2) mem = '{default: 16'hFFFF};
        if (pins.reset_n && op == 1) mem[pa] &= pd;
        {op, win, ers} = 0;
        rdy = 1;
    endtask
    task automatic go(input int o);
        op = o;
        gen++;
        fork run(gen); join_none
    endtask
    always @(posedge pins.we_n) begin
        d = pins.dq_out;
        if (!pins.ce_n && pins.reset_n && rdy) begin
            if (win && d != D_SECTOR) {win, op} = 0;
            if (d == D_RESET) {step, idm} = 0;
            else case (step)
                0: begin
                    if (win) go(2);
                    step = (d == D_UNLOCK1 && pins.addr[11:0] == A_U1_WORD) ? 1 :
                        ((byp || acc) && d == D_PROG) ? 3 : (byp && d == D_AUTOSEL) ? 5 : 0;
                end
                1: step = (d == D_UNLOCK2 && pins.addr[11:0] == A_U2_WORD) ? 2 : 0;
                2: begin
                    step = 0;
                    case (d)
                        D_AUTOSEL: {idm, step} = {1'b1, (sec ? 32'h6 : 32'h0)};
                        D_SECURE: sec = 1;
                        D_PROG: step = 3;
                        D_BYPASS: byp = !sec;
                        D_ERASE_SETUP: ers = 1;
                        D_CHIP: if (ers) go(2);
                        D_SECTOR: if (ers) {win, op} = {1'b1, 32'd1};
                        default: ers = 0;
                    endcase
                    if (win && op == 1) go(2);
                end
                3: {pa, pd, step} = {pins.addr[3:0], d, 32'h0};
                5: {byp, step} = {d != D_EXIT, 32'h0};
                default: {sec, idm, step} = 0;
            endcase
            if (step == 0 && op == 0 && pd === d && pa === pins.addr[3:0]) go(1);
        end
    end
endmodule

// file: fcs_host_bench.sv
`timescale 1ns/10ps
module fcs_host_bench import fcs_pkg::*;;
    localparam logic [15:0] ID = 16'h5A5A; // Arbitrary value
    logic core_clk, srst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ready_busy_output;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [FCS_DW-1:0] flash_dq_in;
    fcs_pins_type flash_pins;
    int error_cnt = 0, compares = 0;
    fcs_host i_fcs_host (.core_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_pins,
        .flash_dq_in, .ready_busy_output);
    fcs_flash_model #(.ID_CODE(ID)) i_fcs_flash_model (.pins(flash_pins), .dq(flash_dq_in), .rdy(ready_busy_output));
    initial begin
        core_clk = 0;
        forever #25 core_clk = ~core_clk;
    end
    task end_sim;
        $display("mismatches %0d in %0d compares", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        {ta, tw} = 2'b00;
        while (!(ta && tw)) begin
            @(negedge core_clk);
            ta = ta || s_axi_awready;
            tw = tw || s_axi_wready;
            @(posedge core_clk);
            {s_axi_awvalid, s_axi_wvalid} <= {!ta, !tw};
        end
        do @(negedge core_clk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        @(posedge core_clk);
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do @(negedge core_clk); while (!s_axi_arready);
        @(posedge core_clk);
        s_axi_arvalid <= 0;
        do @(negedge core_clk); while (!s_axi_rvalid);
        {rv, resp} = {s_axi_rdata, s_axi_rresp};
        @(posedge core_clk);
    endtask
    task cmd(input logic [3:0] c);
        wr(REG_CMD, {28'h0, c});
        do rd(REG_STATUS); while (rv[ST_BUSY]);
    endtask
    task done;
        do rd(REG_STATUS); while (rv[ST_READY]);
        do rd(REG_STATUS); while (!rv[ST_READY]);
    endtask
    task pg(input logic [15:0] d, input logic [3:0] c);
        wr(REG_DATA, {16'h0, d});
        cmd(c);
        done;
    endtask
    task st(input int b, input logic v);
        rd(REG_STATUS);
        chk(rv[b], v);
        if (b == ST_REFUSED) wr(REG_STATUS, 32'h2);
    endtask
    task tc(input logic [3:0] c, input int b, input logic v);
        cmd(c);
        st(b, v);
    endtask
    task frd(input logic [15:0] e);
        cmd(CMD_READ);
        rd(REG_RDATA);
        chk(rv, {16'h0, e});
    endtask
    initial begin
        #(4000000);
        error_cnt++;
        end_sim;
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_rready, srst, s_axi_wstrb} = 7'h7F;
        repeat (4) @(posedge core_clk);
        srst <= 0;
        rd(REG_STATUS);
        chk(rv, 32'h40);
        rd(8'h18);
        chk({rv, resp}, {32'h0, RESP_SLVERR});
        wr(8'h18, 32'h0);
        chk(resp, RESP_SLVERR);
        wr(REG_ADDR, 32'h3);
        pg(16'h1234, CMD_PROG);
        frd(16'h1234);
        pg(16'h00FF, CMD_PROG);
        frd(16'h0034);
        tc(CMD_AUTOSEL, ST_AUTOSEL, 1);
        frd(ID);
        tc(CMD_PROG, ST_REFUSED, 1);
        tc(CMD_RESET, ST_AUTOSEL, 0);
        tc(CMD_SEC_ENTER, ST_SECURE, 1);
        tc(CMD_BYP_ENTER, ST_REFUSED, 1);
        tc(CMD_SEC_EXIT, ST_SECURE, 0);
        tc(CMD_BYP_ENTER, ST_BYPASS, 1);
        pg(16'h0030, CMD_BYP_PROG);
        frd(16'h0030);
        tc(CMD_PROG, ST_REFUSED, 1);
        tc(CMD_BYP_RESET, ST_BYPASS, 0);
        tc(CMD_SECT_ERASE, ST_WINDOW, 1);
        tc(CMD_RESET, ST_WINDOW, 0);
        tc(CMD_SUSPEND, ST_REFUSED, 1);
        frd(16'h0030);
        cmd(CMD_SECT_ERASE);
        tc(CMD_SECT_ADD, ST_WINDOW, 1);
        done;
        frd(16'hFFFF);
        pg(16'h0000, CMD_PROG);
        pg(16'h0000, CMD_CHIP_ERASE);
        frd(16'hFFFF);
        cmd(CMD_PROG);
        wr(REG_CTRL, 32'h4);
        wr(REG_CTRL, 32'h0);
        frd(16'hFFFF);
        wr(REG_CTRL, 32'h2);
        st(ST_BYPASS, 1);
        end_sim;
    end
endmodule
